// *** design/sadc_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the converter sequencer.
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH
// Byte addresses of the registers on the AXI4-Lite bus.
`define SADC_OFS_MODE 8'h00
`define SADC_OFS_MODE2 8'h04
`define SADC_OFS_RESH 8'h08
`define SADC_OFS_RESL 8'h0C
`define SADC_OFS_TRIM 8'h10
// Field positions in the converter mode register.
`define SADC_SEL_LSB 0
`define SADC_SEL_MSB 3
`define SADC_START_BIT 4
`define SADC_CONVERTER_STANDBY_BIT 5
`define SADC_DONE_BIT 6
// Field positions in the second mode register (hardware trigger enables).
`define SADC_TEN_LSB 0
`define SADC_TEN_MSB 3
// Reset values.
`define SADC_RST_SEL 4'h0
`define SADC_RST_TEN 4'h0
`define SADC_RST_TRIM 8'h00
// Address of the zero offset trim byte in option memory.
`define SADC_TRIM_OPT_ADDR 16'h1868
// AXI responses.
`define SADC_RESP_OKAY 2'h0
`define SADC_RESP_DECERR 2'h3
// Timing: system clock period in ns, converter clock period in ns and the derived divider.
`define SADC_CLK_NS 25
`define SADC_CONVERTER_CLOCK_NS 200
`define SADC_DIV_CYC (`SADC_CONVERTER_CLOCK_NS / `SADC_CLK_NS)
// Converter clocks per conversion, sampling clocks, first trial code.
`define SADC_CONV_CONVERTER_CLOCK 60
`define SADC_SAMPLE_CONVERTER_CLOCK 12
`define SADC_MSB_CODE 12'h800
`endif

// *** design/sadc_pkg.sv ***
// Types shared by the converter sequencer design.
`default_nettype none
package sadc_pkg;
  // Sequencer states.
  typedef enum logic [0:0] {
    SADC_IDLE = 1'b0,
    SADC_CONV = 1'b1
  } sadc_state_t;
  // Signals towards the analog multiplexer and comparator.
  typedef struct packed {
    logic powerdown;
    logic sample;
    logic [3:0] sel;
    logic [11:0] code;
  } sadc_ana_t;
endpackage
`default_nettype wire

// *** design/sadc_top.sv ***
// Successive-approximation converter sequencer with an AXI4-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
`include "sadc_regs.svh"
module sadc_top #(
  parameter logic [7:0] TRIM_VALUE = `SADC_RST_TRIM
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic cmp_in,
  input wire logic [3:0] trig_in,
  output var sadc_pkg::sadc_ana_t ana_out,
  output logic conv_irq
);
  // Bus handshake and register state.
  logic awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic nxt_awready, nxt_wready, nxt_bvalid, nxt_arready, nxt_rvalid;
  logic [1:0] bresp_ff, rresp_ff, nxt_bresp, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [3:0] sel_ff, nxt_sel; // Channel select field.
  logic converter_standby_ff, nxt_converter_standby; // Standby bit.
  logic [3:0] ten_ff, nxt_ten; // Hardware trigger enables.
  // Conversion state.
  sadc_pkg::sadc_state_t st_ff, nxt_st;
  sadc_pkg::sadc_ana_t ana_ff, nxt_ana;
  logic start_ff, nxt_start; // Start bit, high while a conversion runs.
  logic done_ff, nxt_done; // Completion flag.
  logic irq_ff, nxt_irq; // One-cycle interrupt request.
  logic [11:0] res_ff, nxt_res; // Result word.
  logic [5:0] cnt_ff, nxt_cnt; // Converter clocks elapsed.
  logic [2:0] div_ff, nxt_div; // Converter clock divider.
  // Input synchronisers for the comparator and the triggers.
  logic [4:0] syn1_ff, syn2_ff, syn3_ff, filt_ff, nxt_filt;
  // Decoded bus and trigger events, converter clock tick and bit-decision helpers.
  logic wr_go, rd_go, sw_go, hw_go, tick;
  logic [5:0] ph;
  logic [3:0] bidx;
  logic [11:0] dec;

  assign wr_go = awready_ff && awvalid && wvalid;
  assign rd_go = arready_ff && arvalid;
  assign tick = (div_ff == 3'(`SADC_DIV_CYC - 1));

  // Bus next-state logic: accepts address and data together, answers one cycle later.
  always_comb begin
    nxt_awready = 1'b0;
    nxt_wready = 1'b0;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_arready = 1'b0;
    nxt_rvalid = rvalid_ff;
    nxt_rresp = rresp_ff;
    nxt_rdata = rdata_ff;
    nxt_sel = sel_ff;
    nxt_converter_standby = converter_standby_ff;
    nxt_ten = ten_ff;
    // Write response leaves once the master takes it.
    if (bvalid_ff && bready) begin
      nxt_bvalid = 1'b0;
    end
    // Both write channels are taken in the same cycle, only with no answer pending.
    if (awvalid && wvalid && !awready_ff && !bvalid_ff) begin
      nxt_awready = 1'b1;
      nxt_wready = 1'b1;
    end
    if (wr_go) begin
      nxt_bvalid = 1'b1;
      nxt_bresp = `SADC_RESP_OKAY;
      case (awaddr)
        `SADC_OFS_MODE: begin
          if (wstrb[0]) begin
            nxt_sel = wdata[`SADC_SEL_MSB:`SADC_SEL_LSB];
            nxt_converter_standby = wdata[`SADC_CONVERTER_STANDBY_BIT];
          end
        end
        `SADC_OFS_MODE2: begin
          if (wstrb[0]) begin
            nxt_ten = wdata[`SADC_TEN_MSB:`SADC_TEN_LSB];
          end
        end
        `SADC_OFS_RESH, `SADC_OFS_RESL, `SADC_OFS_TRIM: begin
          nxt_bresp = `SADC_RESP_OKAY;
        end
        default: begin
          nxt_bresp = `SADC_RESP_DECERR;
        end
      endcase
    end
    // Read answer leaves once the master takes it.
    if (rvalid_ff && rready) begin
      nxt_rvalid = 1'b0;
    end
    if (arvalid && !arready_ff && !rvalid_ff) begin
      nxt_arready = 1'b1;
    end
    if (rd_go) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `SADC_RESP_OKAY;
      nxt_rdata = 32'h0000_0000;
      case (araddr)
        `SADC_OFS_MODE: begin
          nxt_rdata[`SADC_SEL_MSB:`SADC_SEL_LSB] = sel_ff;
          nxt_rdata[`SADC_START_BIT] = start_ff;
          nxt_rdata[`SADC_CONVERTER_STANDBY_BIT] = converter_standby_ff;
          nxt_rdata[`SADC_DONE_BIT] = done_ff;
        end
        `SADC_OFS_MODE2: begin
          nxt_rdata[`SADC_TEN_MSB:`SADC_TEN_LSB] = ten_ff;
        end
        `SADC_OFS_RESH: begin
          nxt_rdata[7:0] = res_ff[11:4];
        end
        `SADC_OFS_RESL: begin
          nxt_rdata[3:0] = res_ff[3:0];
        end
        `SADC_OFS_TRIM: begin
          nxt_rdata[7:0] = TRIM_VALUE;
        end
        default: begin
          nxt_rresp = `SADC_RESP_DECERR;
        end
      endcase
    end
  end

  // Bus and register flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `SADC_RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= `SADC_RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
      sel_ff <= `SADC_RST_SEL;
      converter_standby_ff <= 1'b0;
      ten_ff <= `SADC_RST_TEN;
    end else begin
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rresp_ff <= nxt_rresp;
      rdata_ff <= nxt_rdata;
      sel_ff <= nxt_sel;
      converter_standby_ff <= nxt_converter_standby;
      ten_ff <= nxt_ten;
    end
  end

  // A filtered input follows only once the second and third stages agree.
  always_comb begin
    nxt_filt = (syn2_ff & syn3_ff) | (filt_ff & (syn2_ff ^ syn3_ff));
  end

  // Three-stage synchronisers; bit 0 is the comparator, bits 4..1 the triggers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      syn1_ff <= 5'h00;
      syn2_ff <= 5'h00;
      syn3_ff <= 5'h00;
      filt_ff <= 5'h00;
    end else begin
      syn1_ff <= {trig_in, cmp_in};
      syn2_ff <= syn1_ff;
      syn3_ff <= syn2_ff;
      filt_ff <= nxt_filt;
    end
  end

  // Software start is taken with the mode write itself, unless it also enters standby.
  assign sw_go = wr_go && (awaddr == `SADC_OFS_MODE) && wstrb[0] && wdata[`SADC_START_BIT]
    && !wdata[`SADC_CONVERTER_STANDBY_BIT];
  // A rising trigger starts a conversion when its enable is set.
  assign hw_go = |(nxt_filt[4:1] & ~filt_ff[4:1] & ten_ff);

  // Conversion next-state logic: sampling, then one bit per four converter clocks.
  always_comb begin
    nxt_st = st_ff;
    nxt_ana = ana_ff;
    nxt_start = start_ff;
    nxt_done = done_ff;
    nxt_irq = 1'b0;
    nxt_res = res_ff;
    nxt_cnt = cnt_ff;
    nxt_div = tick ? 3'h0 : 3'(div_ff + 3'h1);
    ph = 6'(cnt_ff - 6'(`SADC_SAMPLE_CONVERTER_CLOCK));
    bidx = 4'(4'hB - ph[5:2]);
    dec = ana_ff.code;
    dec[bidx] = filt_ff[0];
    if (bidx != 4'h0) begin
      dec[4'(bidx - 4'h1)] = 1'b1;
    end
    if (nxt_converter_standby) begin
      // Standby aborts any conversion and powers the converter down.
      nxt_st = sadc_pkg::SADC_IDLE;
      nxt_start = 1'b0;
      nxt_ana.powerdown = 1'b1;
      nxt_ana.sample = 1'b0;
    end else begin
      nxt_ana.powerdown = 1'b0;
      case (st_ff)
        sadc_pkg::SADC_IDLE: begin
          if (sw_go || hw_go) begin
            nxt_st = sadc_pkg::SADC_CONV;
            nxt_cnt = 6'h00;
            nxt_start = 1'b1;
            nxt_done = 1'b0;
            nxt_ana.sel = nxt_sel;
            nxt_ana.sample = 1'b1;
            nxt_ana.code = 12'h000;
          end
        end
        sadc_pkg::SADC_CONV: begin
          if (tick) begin
            nxt_cnt = 6'(cnt_ff + 6'h01);
            if (cnt_ff == 6'(`SADC_SAMPLE_CONVERTER_CLOCK - 1)) begin
              nxt_ana.sample = 1'b0;
              nxt_ana.code = `SADC_MSB_CODE;
            end else if (cnt_ff >= 6'(`SADC_SAMPLE_CONVERTER_CLOCK) && ph[1:0] == 2'h3) begin
              nxt_ana.code = dec;
            end
            if (cnt_ff == 6'(`SADC_CONV_CONVERTER_CLOCK - 1)) begin
              nxt_st = sadc_pkg::SADC_IDLE;
              nxt_res = dec;
              nxt_done = 1'b1;
              nxt_irq = 1'b1;
              nxt_start = 1'b0;
              nxt_ana.code = 12'h000;
            end
          end
        end
        default: begin
          nxt_st = sadc_pkg::SADC_IDLE;
        end
      endcase
    end
  end

  // Conversion flip-flops.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= sadc_pkg::SADC_IDLE;
      ana_ff <= '0;
      start_ff <= 1'b0;
      done_ff <= 1'b0;
      irq_ff <= 1'b0;
      res_ff <= 12'h000;
      cnt_ff <= 6'h00;
      div_ff <= 3'h0;
    end else begin
      st_ff <= nxt_st;
      ana_ff <= nxt_ana;
      start_ff <= nxt_start;
      done_ff <= nxt_done;
      irq_ff <= nxt_irq;
      res_ff <= nxt_res;
      cnt_ff <= nxt_cnt;
      div_ff <= nxt_div;
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rresp = rresp_ff;
  assign rdata = rdata_ff;
  assign ana_out = ana_ff;
  assign conv_irq = irq_ff;

  // Cycles spent converting, read only by the checks below.
  logic [9:0] hlp_cyc_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || st_ff != sadc_pkg::SADC_CONV) begin
      hlp_cyc_ff <= 10'h000;
    end else begin
      hlp_cyc_ff <= 10'(hlp_cyc_ff + 10'h001);
    end
  end

  // Checks on the conversion sequence.
  a_conv_length: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(done_ff) |-> ($past(hlp_cyc_ff) >= 10'h1D8 && $past(hlp_cyc_ff) <= 10'h1DF))
    else $error("Conversion length is not sixty converter clocks.");
  a_done_busy_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    st_ff == sadc_pkg::SADC_CONV |-> !done_ff)
    else $error("Completion flag high during conversion.");
  a_irq_with_done: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_ff |-> $rose(done_ff) && st_ff == sadc_pkg::SADC_IDLE)
    else $error("Interrupt without completion.");
  a_start_self_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(done_ff) |-> !start_ff && $past(start_ff))
    else $error("Start bit not cleared at completion.");
  a_result_bits: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(done_ff) |-> res_ff[11:1] == $past(ana_ff.code[11:1]) && res_ff[0] == $past(filt_ff[0]))
    else $error("Result does not match the decided bits.");
  a_converter_standby_holds_off: assert property (@(posedge aclk) disable iff (!aresetn)
    converter_standby_ff |-> st_ff == sadc_pkg::SADC_IDLE && ana_ff.powerdown)
    else $error("Converter active in standby.");
  a_chan_routed: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(st_ff == sadc_pkg::SADC_CONV) |-> ana_ff.sel == sel_ff && ana_ff.sample)
    else $error("Wrong channel routed at start.");
  a_sw_start: assert property (@(posedge aclk) disable iff (!aresetn)
    sw_go && st_ff == sadc_pkg::SADC_IDLE |=> st_ff == sadc_pkg::SADC_CONV && start_ff)
    else $error("Software start not taken.");
  a_hw_start: assert property (@(posedge aclk) disable iff (!aresetn)
    hw_go && !nxt_converter_standby && st_ff == sadc_pkg::SADC_IDLE |=> st_ff == sadc_pkg::SADC_CONV)
    else $error("Trigger start not taken.");
  c_conv_done: cover property (@(posedge aclk) disable iff (!aresetn) $rose(done_ff));
  c_hw_started: cover property (@(posedge aclk) disable iff (!aresetn)
    hw_go && st_ff == sadc_pkg::SADC_IDLE);
  c_converter_standby_abort: cover property (@(posedge aclk) disable iff (!aresetn)
    st_ff == sadc_pkg::SADC_CONV && nxt_converter_standby);
endmodule
`default_nettype wire

// *** tb/sadc_cmp_model.sv ***
// Behavioural analog multiplexer and comparator that face the converter sequencer.
`timescale 1ns/1ps
`default_nettype none
module sadc_cmp_model (
  input wire logic aclk,
  input wire sadc_pkg::sadc_ana_t ana_out,
  output logic cmp_in
);
  // Channel held by the multiplexer, caught while sampling.
  logic [3:0] ch_ff = 4'h0;
  // Analog level of the held channel, a fixed pattern per channel.
  logic [11:0] lvl;
  // Only the analog level reaches the comparator; the pins are taken as set to analog use.
  assign lvl = {ch_ff, ch_ff, ch_ff} ^ 12'hA5C;
  initial cmp_in = 1'b0;
  // Compare the level with the trial code; a powered-down comparator toggles every cycle.
  always @(posedge aclk) begin
    if (ana_out.sample) begin
      ch_ff <= ana_out.sel;
    end
    cmp_in <= ana_out.powerdown ? ~cmp_in : (lvl >= ana_out.code);
  end
endmodule
`default_nettype wire

// *** tb/tb_sadc_top.sv ***
// Self-checking bench of the converter sequencer over its register bus.
`timescale 1ns/1ps
`default_nettype none
`include "sadc_regs.svh"
module tb_sadc_top;
  localparam logic [7:0] TRIM = 8'hF5;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hF, trig_in = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, cmp_in, conv_irq;
  logic [1:0] bresp, rresp, rs;
  logic [11:0] ex;
  sadc_pkg::sadc_ana_t ana_out;
  int failures = 0, samples_checked = 0, cyc = 0, t0 = 0, dt, k;
  // Clock and a free cycle count used to time conversions.
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  sadc_top #(.TRIM_VALUE(TRIM)) sadc_top_i (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .cmp_in(cmp_in), .trig_in(trig_in),
    .ana_out(ana_out), .conv_irq(conv_irq));
  sadc_cmp_model sadc_cmp_model_i (.aclk(aclk), .ana_out(ana_out), .cmp_in(cmp_in));
  // Prints the counts and the verdict, then ends the run.
  task summarize;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Compares one value with its expectation.
  task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // A wait that ran out counts as a mismatch and ends the run.
  task hang(input logic ok);
    if (ok !== 1'b1) begin
      failures++;
      $display("wrong value at %0t: handshake timeout", $time);
      summarize();
    end
  endtask
  // One register write; t0 marks the edge where it is applied.
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (awready !== 1'b1 && n < 50);
    hang(awready & wready);
    t0 = cyc;
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    n = 0;
    do begin @(posedge aclk); n++; end while (bvalid !== 1'b1 && n < 50);
    hang(bvalid);
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  // One register read into rd and rs.
  task rdr(input logic [7:0] a);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 50);
    hang(arready);
    arvalid <= 1'b0;
    n = 0;
    do begin @(posedge aclk); n++; end while (rvalid !== 1'b1 && n < 50);
    hang(rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Waits a bounded time for the interrupt; dt is -1 when none came.
  task wait_irq;
    int n;
    n = 0;
    do begin @(posedge aclk); n++; end while (conv_irq !== 1'b1 && n < 700);
    dt = (conv_irq === 1'b1) ? cyc - t0 : -1;
  endtask
  // Software-started conversion of one channel, read once while busy, then awaited by interrupt.
  task conv(input logic [3:0] c);
    ex = {c, c, c} ^ 12'hA5C;
    wr(`SADC_OFS_MODE, {28'h1, c});
    rdr(`SADC_OFS_MODE);
    check(rd & 32'h7F, {28'h1, c}, "busy mode");
    check({28'h0, ana_out.sel}, {28'h0, c}, "mux channel");
    wait_irq();
    check(32'(dt >= 473 && dt <= 481), 32'h1, "conversion length");
    rdr(`SADC_OFS_MODE);
    check(rd & 32'h70, 32'h40, "done mode");
    rdr(`SADC_OFS_RESH);
    check(rd, {24'h0, ex[11:4]}, "result high");
    rdr(`SADC_OFS_RESL);
    check(rd, {28'h0, ex[3:0]}, "result low");
  endtask
  // Main sequence.
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(`SADC_OFS_MODE);
    check(rd, 32'h0, "mode reset");
    rdr(`SADC_OFS_TRIM);
    check(rd, {24'h0, TRIM}, "trim byte");
    rdr(8'h20);
    check({rd[30:0], rs[0]}, 32'h1, "unmapped read");
    wr(8'h20, 32'hFF);
    check({30'h0, rs}, {30'h0, `SADC_RESP_DECERR}, "unmapped write");
    for (k = 0; k < 16; k += 5) begin
      conv(k[3:0]);
    end
    wr(`SADC_OFS_RESH, 32'hFF);
    check({30'h0, rs}, {30'h0, `SADC_RESP_OKAY}, "result write response");
    rdr(`SADC_OFS_RESH);
    check(rd, {24'h0, ex[11:4]}, "result kept");
    // Standby entered mid-conversion in the same write as a start, then a trigger: nothing may convert.
    wr(`SADC_OFS_MODE, 32'h11);
    wr(`SADC_OFS_MODE2, 32'h1);
    rdr(`SADC_OFS_MODE2);
    check(rd, 32'h1, "trigger enables");
    wr(`SADC_OFS_MODE, 32'h31);
    trig_in <= 4'h1;
    rdr(`SADC_OFS_MODE);
    check(rd & 32'h70, 32'h20, "standby mode");
    check({31'h0, ana_out.powerdown}, 32'h1, "powered down");
    wait_irq();
    check(dt, -1, "standby idle");
    trig_in <= 4'h0;
    // The first conversion after leaving standby may be inaccurate; its result is thrown away.
    wr(`SADC_OFS_MODE, 32'h10);
    wait_irq();
    check(32'(dt > 0), 32'h1, "settling conversion");
    // Every hardware trigger input starts a conversion.
    for (k = 0; k < 4; k++) begin
      wr(`SADC_OFS_MODE, 32'(k + 3));
      wr(`SADC_OFS_MODE2, 32'h1 << k);
      trig_in <= 4'h1 << k;
      repeat (8) @(posedge aclk);
      trig_in <= 4'h0;
      wait_irq();
      check(32'(dt > 0), 32'h1, "trigger start");
      ex = {k[3:0] + 4'h3, k[3:0] + 4'h3, k[3:0] + 4'h3} ^ 12'hA5C;
      rdr(`SADC_OFS_RESH);
      check(rd, {24'h0, ex[11:4]}, "trigger result");
    end
    summarize();
  end
endmodule
`default_nettype wire
